// file: design/bsce_pkg.sv
// Shared constants and types for the bit-test, call, clear and complement executor
package bsce_pkg;
  localparam int PC_W       = 10;
  localparam int STACK_N    = 8;
  localparam int SP_W       = 3;
  localparam int RF_N       = 64;
  localparam int RF_AW      = 6;
  localparam int BUS_AW     = 12;
  // Instruction word fields
  localparam int OP_HI      = 15;
  localparam int OP_LO      = 12;
  localparam int DST_POS    = 9;
  localparam int BIT_HI     = 8;
  localparam int BIT_LO     = 6;
  localparam int REG_HI     = 5;
  localparam int IMM_HI     = 7;
  // Opcodes
  localparam logic [3:0] OP_NOP   = 4'h0;
  localparam logic [3:0] OP_BTSC  = 4'h1;
  localparam logic [3:0] OP_BTSS  = 4'h2;
  localparam logic [3:0] OP_CALL  = 4'h3;
  localparam logic [3:0] OP_CALL_IND  = 4'h4;
  localparam logic [3:0] OP_CLR_ACCUM = 4'h5;
  localparam logic [3:0] OP_CLR_REG   = 4'h6;
  localparam logic [3:0] OP_COMP_REG  = 4'h7;
  // Register map (byte addresses)
  localparam logic [11:0] ADR_CTRL   = 12'h000;
  localparam logic [11:0] ADR_STATUS = 12'h004;
  localparam logic [11:0] ADR_ACCUM    = 12'h008;
  localparam logic [11:0] ADR_PAGE_BUF = 12'h00C;
  localparam logic [11:0] ADR_TBL_PTR  = 12'h010;
  localparam logic [11:0] ADR_RF     = 12'h100;
  localparam int STAT_SP_LO = 16;
  localparam int STAT_Z_POS = 24;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] BYTE_ZERO   = 8'h00;
  localparam logic [PC_W-1:0] PC_RST = 10'h000;
  localparam logic [PC_W-1:0] PC_ONE = 10'h001;
  localparam logic [SP_W-1:0] SP_RST = 3'h0;

  typedef struct packed {
    logic [3:0]       op;
    logic             dst;
    logic [2:0]       bsel;
    logic [RF_AW-1:0] raddr;
    logic [7:0]       imm;
  } bsce_instr_s;
endpackage : bsce_pkg

// file: design/bsce_regfile.sv
// General register file: two asynchronous read ports, one write port
`timescale 1ns/100ps
`default_nettype none
module bsce_regfile
  import bsce_pkg::*;
(
  input  wire logic             clk,   // Core clock
  input  wire logic             we,    // Write enable
  input  wire logic [RF_AW-1:0] waddr, // Write address
  input  wire logic [7:0]       wdata, // Write data
  input  wire logic [RF_AW-1:0] raddr_a, // Core read address
  output logic      [7:0]       rdata_a, // Core read data
  input  wire logic [RF_AW-1:0] raddr_b, // Bus read address
  output logic      [7:0]       rdata_b  // Bus read data
);
  logic [7:0] mem [RF_N];

  // Contents are left uninitialised, as in the real array
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata_a = mem[raddr_a];
  assign rdata_b = mem[raddr_b];
endmodule : bsce_regfile
`default_nettype wire

// file: design/bsce_exec.sv
// Executor for bit-test skips, calls, clears and complement, with an AXI4-Lite register slave
`timescale 1ns/100ps
`default_nettype none
module bsce_exec
  import bsce_pkg::*;
(
  input  wire logic              clk,       // 20 MHz core clock
  input  wire logic              srst,      // Synchronous reset, active high
  input  wire logic              ce,        // Clock enable, freezes all state when low
  output logic      [PC_W-1:0]   prog_addr, // Program memory fetch address
  input  wire logic [15:0]       prog_word, // Word at last cycle's fetch address
  input  wire logic              awvalid,   // AXI write address valid
  output logic                   awready,   // AXI write address ready
  input  wire logic [BUS_AW-1:0] awaddr,    // AXI write address
  input  wire logic              wvalid,    // AXI write data valid
  output logic                   wready,    // AXI write data ready
  input  wire logic [31:0]       wdata,     // AXI write data
  input  wire logic [3:0]        wstrb,     // AXI write strobes
  output logic                   bvalid,    // AXI write response valid
  input  wire logic              bready,    // AXI write response ready
  output logic      [1:0]        bresp,     // AXI write response
  input  wire logic              arvalid,   // AXI read address valid
  output logic                   arready,   // AXI read address ready
  input  wire logic [BUS_AW-1:0] araddr,    // AXI read address
  output logic                   rvalid,    // AXI read data valid
  input  wire logic              rready,    // AXI read data ready
  output logic      [31:0]       rdata,     // AXI read data
  output logic      [1:0]        rresp      // AXI read response
);
  import bsce_pkg::*;

  logic [PC_W-1:0] fetch_pc_r, exec_pc_r;
  logic            flush_r, run_r, zero_r;
  logic [7:0]      accumulator_r;
  logic [1:0]      pc_high_page_buffer_r, table_high_pointer_r;
  logic [PC_W-1:0] stack_r [STACK_N];
  logic [SP_W-1:0] sp_r;
  logic [7:0]      rd_val, bus_rf_val;
  bsce_instr_s     ins;

  // Field split of the word on the program bus
  assign ins.op    = prog_word[OP_HI:OP_LO];
  assign ins.dst   = prog_word[DST_POS];
  assign ins.bsel  = prog_word[BIT_HI:BIT_LO];
  assign ins.raddr = prog_word[REG_HI:0];
  assign ins.imm   = prog_word[IMM_HI:0];

  logic advance, exec_go, is_call, skip_take, core_we;
  logic [PC_W-1:0] call_tgt;
  logic [7:0]      comp_val;
  assign advance   = ce && run_r;
  assign exec_go   = advance && !flush_r;  // A flushed word executes as a no-op
  assign is_call   = exec_go && (ins.op == OP_CALL || ins.op == OP_CALL_IND);
  assign skip_take = exec_go && ((ins.op == OP_BTSC && !rd_val[ins.bsel])
                              || (ins.op == OP_BTSS &&  rd_val[ins.bsel]));
  assign comp_val  = ~rd_val;
  assign call_tgt  = (ins.op == OP_CALL) ? {pc_high_page_buffer_r, ins.imm}
                                         : {table_high_pointer_r, accumulator_r};
  assign core_we   = exec_go && (ins.op == OP_CLR_REG || (ins.op == OP_COMP_REG && ins.dst));
  assign prog_addr = fetch_pc_r;

  // Bus side of the register file is only open while the core is halted
  logic            aw_held_r, w_held_r;
  logic [BUS_AW-1:0] aw_addr_r;
  logic [31:0]     w_data_r;
  logic [3:0]      w_strb_r;
  logic            wr_fire, rf_bus_hit_w, rf_bus_we;
  assign wr_fire      = ce && aw_held_r && w_held_r && !bvalid;
  assign rf_bus_hit_w = (aw_addr_r[11:8] == ADR_RF[11:8]);
  // A misaligned address is answered with an error, so it must not write either
  assign rf_bus_we    = wr_fire && rf_bus_hit_w && (aw_addr_r[1:0] == 2'h0) && !run_r
                        && w_strb_r[0];

  bsce_regfile u_rf (
    .clk     (clk),
    .we      ((ce && core_we) || rf_bus_we),
    .waddr   (core_we ? ins.raddr : aw_addr_r[7:2]),
    .wdata   (core_we ? ((ins.op == OP_CLR_REG) ? BYTE_ZERO : comp_val) : w_data_r[7:0]),
    .raddr_a (ins.raddr),
    .rdata_a (rd_val),
    .raddr_b (araddr[7:2]),
    .rdata_b (bus_rf_val)
  );

  // Fetch and execute pointers; a taken skip or a call discards the prefetched word
  always_ff @(posedge clk) begin
    if (srst) begin
      fetch_pc_r <= PC_RST;
      exec_pc_r  <= PC_RST;
      flush_r    <= 1'b1;  // First word after reset is not yet valid
    end else if (advance) begin
      exec_pc_r  <= fetch_pc_r;
      fetch_pc_r <= is_call ? call_tgt : fetch_pc_r + PC_ONE;
      flush_r    <= skip_take || is_call;
    end
  end

  // Return stack push
  always_ff @(posedge clk) begin
    if (srst) begin
      sp_r <= SP_RST;
    end else if (ce && is_call) begin
      stack_r[sp_r] <= exec_pc_r + PC_ONE;
      sp_r          <= sp_r + 3'h1;
    end
  end

  // Accumulator and zero flag; a bus write to the accumulator yields only to a core write of it
  always_ff @(posedge clk) begin
    if (srst) begin
      accumulator_r <= BYTE_ZERO;
      zero_r        <= 1'b0;
    end else if (ce) begin
      if (exec_go && (ins.op == OP_CLR_ACCUM || ins.op == OP_CLR_REG)) begin
        zero_r <= 1'b1;
      end else if (exec_go && ins.op == OP_COMP_REG) begin
        zero_r <= (comp_val == BYTE_ZERO);
      end
      if (exec_go && ins.op == OP_CLR_ACCUM) begin
        accumulator_r <= BYTE_ZERO;
      end else if (exec_go && ins.op == OP_COMP_REG && !ins.dst) begin
        accumulator_r <= comp_val;
      end else if (wr_fire && aw_addr_r == ADR_ACCUM && w_strb_r[0]) begin
        accumulator_r <= w_data_r[7:0];
      end
    end
  end

  // Control and page pointer registers written from the bus
  always_ff @(posedge clk) begin
    if (srst) begin
      run_r                 <= 1'b0;
      pc_high_page_buffer_r <= 2'h0;
      table_high_pointer_r  <= 2'h0;
    end else if (wr_fire && w_strb_r[0]) begin
      if (aw_addr_r == ADR_CTRL)   run_r                 <= w_data_r[0];
      if (aw_addr_r == ADR_PAGE_BUF) pc_high_page_buffer_r <= w_data_r[1:0];
      if (aw_addr_r == ADR_TBL_PTR)  table_high_pointer_r  <= w_data_r[1:0];
    end
  end

  // Write channel: address and data are taken in either order, answer follows both
  assign awready = ce && !aw_held_r;
  assign wready  = ce && !w_held_r;
  always_ff @(posedge clk) begin
    if (srst) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      aw_addr_r <= '0;
      w_data_r  <= '0;
      w_strb_r  <= '0;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= awaddr;
      end
      if (wvalid && wready) begin
        w_held_r <= 1'b1;
        w_data_r <= wdata;
        w_strb_r <= wstrb;
      end
      if (wr_fire) begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= (wr_map_ok(aw_addr_r) && !(rf_bus_hit_w && run_r)) ? RESP_OKAY
                                                                         : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Decode shared by both channels
  function automatic logic wr_map_ok(input logic [BUS_AW-1:0] a);
    wr_map_ok = (a[1:0] == 2'h0) && (a[11:8] == ADR_RF[11:8] || a == ADR_CTRL ||
                a == ADR_ACCUM || a == ADR_PAGE_BUF || a == ADR_TBL_PTR || a == ADR_STATUS);
  endfunction : wr_map_ok

  // Read channel: one cycle from address to data
  assign arready = ce && !rvalid;
  always_ff @(posedge clk) begin
    if (srst) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rresp  <= RESP_OKAY;
        rdata  <= '0;
        if (!wr_map_ok(araddr) || (araddr[11:8] == ADR_RF[11:8] && run_r)) begin
          rresp <= RESP_SLVERR;
        end else if (araddr[11:8] == ADR_RF[11:8]) begin
          rdata[7:0] <= bus_rf_val;
        end else if (araddr == ADR_CTRL) begin
          rdata[0] <= run_r;
        end else if (araddr == ADR_STATUS) begin
          rdata[PC_W-1:0]                  <= exec_pc_r;
          rdata[STAT_SP_LO+SP_W-1:STAT_SP_LO] <= sp_r;
          rdata[STAT_Z_POS]                <= zero_r;
        end else if (araddr == ADR_ACCUM) begin
          rdata[7:0] <= accumulator_r;
        end else if (araddr == ADR_PAGE_BUF) begin
          rdata[1:0] <= pc_high_page_buffer_r;
        end else begin
          rdata[1:0] <= table_high_pointer_r;
        end
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // Checks on the executor
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_call_issue;
    is_call;
  endsequence
  sequence s_call_done;
    flush_r && prog_addr == $past(call_tgt) && sp_r == $past(sp_r) + 3'h1;
  endsequence

  a_skip_clear_taken: assert property (exec_go && ins.op == OP_BTSC && !rd_val[ins.bsel]
    |=> flush_r) else $error("clear test did not skip");
  a_skip_set_taken: assert property (exec_go && ins.op == OP_BTSS && rd_val[ins.bsel]
    |=> flush_r) else $error("set test did not skip");
  // A discarded word must leave the accumulator, the zero flag and the stack pointer as they were
  a_skip_nop_slot: assert property (advance && flush_r && !wr_fire
    |=> $stable(accumulator_r) && $stable(zero_r) && $stable(sp_r))
    else $error("discarded word had an effect");
  a_noskip_one_cycle: assert property (exec_go && ins.op == OP_BTSS && !rd_val[ins.bsel]
    |=> !flush_r) else $error("untaken test stalled");
  a_call_direct_jump: assert property (s_call_issue |=> s_call_done)
    else $error("call target or stack pointer wrong");
  a_call_push_ret: assert property (s_call_issue
    |=> stack_r[$past(sp_r)] == $past(exec_pc_r) + PC_ONE)
    else $error("return address wrong");
  a_clear_accum_zero: assert property (exec_go && ins.op == OP_CLR_ACCUM
    |=> accumulator_r == BYTE_ZERO && zero_r) else $error("clear accumulator failed");
  a_clear_reg_zero: assert property (exec_go && ins.op == OP_CLR_REG |=> zero_r)
    else $error("clear register left zero low");
  a_comp_accum_dest: assert property (exec_go && ins.op == OP_COMP_REG && !ins.dst
    |=> accumulator_r == ~$past(rd_val) && zero_r == ($past(rd_val) == 8'hFF))
    else $error("complement to accumulator wrong");
endmodule : bsce_exec
`default_nettype wire

// file: tb/bsce_prog_mem.sv
// Program memory model that hands instruction words to the executor
`timescale 1ns/100ps
`default_nettype none
module bsce_prog_mem
  import bsce_pkg::*;
(
  input  wire logic [PC_W-1:0] prog_addr, // Fetch address from the core
  input  wire logic            clk,       // Core clock
  output logic      [15:0]     prog_word  // Word one edge after its address
);
  import bsce_pkg::*;
  logic [15:0] mem [0:(1<<PC_W)-1]; // Loaded by the bench before run

  // Unloaded words read as no-op, so a runaway fetch stays harmless
  initial begin
    for (int i = 0; i < (1 << PC_W); i++) begin
      mem[i] = 16'h0000;
    end
  end

  // Synchronous read: the word lags its address by one edge
  always_ff @(posedge clk) begin
    prog_word <= mem[prog_addr];
  end
endmodule : bsce_prog_mem
`default_nettype wire

// file: tb/bsce_exec_bench.sv
// Self-checking bench: loads registers over the bus, runs a program, reads results back
`timescale 1ns/100ps
`default_nettype none
module bsce_exec_bench;
  import bsce_pkg::*;
  logic clk = 1'b0, srst = 1'b1, ce = 1'b1;
  logic [PC_W-1:0] prog_addr;
  logic [15:0] prog_word;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [BUS_AW-1:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000, rdata, rd;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp, rsp;
  int err_total = 0, checks_done = 0, cyc = 0, t0 = -1, t1 = -1, t2 = -1;

  bsce_exec bsce_exec_inst (.clk(clk), .srst(srst), .ce(ce), .prog_addr(prog_addr),
    .prog_word(prog_word), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
  bsce_prog_mem bsce_prog_mem_inst (.clk(clk), .prog_addr(prog_addr), .prog_word(prog_word));

  always #25 clk = ~clk;

  // Cycle count, fetch-address timestamps and the hang limit
  always @(posedge clk) begin
    cyc++;
    if (prog_addr === 10'h007 && t0 < 0) t0 = cyc;
    if (prog_addr === 10'h240 && t1 < 0) t1 = cyc;
    if (prog_addr === 10'h1A6 && t2 < 0) t2 = cyc;
    if (cyc > 3000) begin
      err_total++;
      final_report();
    end
  end

  task automatic final_report();
    if (err_total == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask : chk

  // Write one word; address and data are offered together, each dropped at the edge it is taken
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    logic done;
    done = 1'b0;
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) begin
        rsp = bresp;
        done = 1'b1;
      end
    end
    bready <= 1'b0;
    // One idle edge, so the next call never drives a signal twice in one time step
    @(posedge clk);
  endtask : axi_wr

  // Read one word; rready stays up until the data is seen at a rising edge
  task automatic axi_rd(input logic [11:0] a);
    logic done;
    done = 1'b0;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) begin
        rd = rdata;
        rsp = rresp;
        done = 1'b1;
      end
    end
    rready <= 1'b0;
    @(posedge clk);
  endtask : axi_rd

  function automatic logic [15:0] ins(input logic [3:0] op, input logic d,
                                      input logic [2:0] b, input logic [5:0] r);
    return {op, 2'b00, d, b, r};
  endfunction : ins

  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    bsce_prog_mem_inst.mem[0] = ins(4'h1, 1'b0, 3'd2, 6'd5);
    bsce_prog_mem_inst.mem[1] = ins(4'h6, 1'b0, 3'd0, 6'd9);
    bsce_prog_mem_inst.mem[2] = ins(4'h2, 1'b0, 3'd2, 6'd5);
    bsce_prog_mem_inst.mem[3] = ins(4'h7, 1'b1, 3'd0, 6'd6);
    bsce_prog_mem_inst.mem[4] = ins(4'h2, 1'b0, 3'd3, 6'd5);
    bsce_prog_mem_inst.mem[5] = ins(4'h6, 1'b0, 3'd0, 6'd6);
    bsce_prog_mem_inst.mem[6] = ins(4'h7, 1'b0, 3'd0, 6'd6);
    bsce_prog_mem_inst.mem[7] = 16'h3040;
    bsce_prog_mem_inst.mem[10'h240] = ins(4'h6, 1'b0, 3'd0, 6'd7);
    bsce_prog_mem_inst.mem[10'h241] = 16'h4000;
    bsce_prog_mem_inst.mem[10'h1A6] = ins(4'h7, 1'b1, 3'd0, 6'd5);
    bsce_prog_mem_inst.mem[10'h1A7] = 16'h5000;
    // Preload while halted: bit 2 of r5 clear, bit 3 set
    axi_wr(12'h114, 32'h0000_005A);
    chk({30'h0, rsp}, {30'h0, RESP_OKAY});
    axi_wr(12'h118, 32'h0000_00A6);
    axi_wr(12'h11C, 32'h0000_0033);
    axi_wr(12'h124, 32'h0000_0077);
    // Misaligned write is refused and must leave r9 untouched
    axi_wr(12'h126, 32'h0000_00EE);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    axi_wr(12'h008, 32'h0000_0034);
    axi_wr(12'h00C, 32'h0000_0002);
    axi_wr(12'h010, 32'h0000_0001);
    axi_rd(12'h008);
    chk(rd, 32'h0000_0034);
    axi_rd(12'h020);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    axi_wr(12'h000, 32'h0000_0001);
    // Register file is closed to the bus while the core runs
    axi_rd(12'h114);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    axi_wr(12'h124, 32'h0000_00EE);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    while (prog_addr !== 10'h1AC) @(posedge clk);
    axi_wr(12'h000, 32'h0000_0000);
    axi_rd(12'h124);
    chk(rd, 32'h0000_0077);
    axi_rd(12'h118);
    chk(rd, 32'h0000_0059);
    axi_rd(12'h11C);
    chk(rd, 32'h0000_0000);
    axi_rd(12'h114);
    chk(rd, 32'h0000_00A5);
    axi_rd(12'h008);
    chk(rd, 32'h0000_0000);
    axi_rd(12'h004);
    chk({28'h0, rd[24], rd[18:16]}, 32'h0000_000A);
    // Call word fetch to target fetch: one discarded fetch lies between
    chk(t1 - t0, 2);
    // One-cycle body, then the two fetch slots of the second call
    chk(t2 - t1, 3);
    final_report();
  end
endmodule : bsce_exec_bench
`default_nettype wire
